// *** verification/mode_link_asserts.sv ***
// Checker for the byte link between the controller and the device.
`timescale 1ns/1ps
module mode_link_asserts (
  input wire logic clock, // Clock.
  input wire logic arst_n, // Reset, low.
  input wire logic ptr_load, // Pointer load.
  input wire logic write, // Write strobe.
  input wire logic read, // Read strobe.
  input wire logic stop, // Transfer end.
  input wire logic soft_reset, // Reset pulse.
  input wire logic [7:0] data, // Sent byte.
  input wire logic [7:0] rdata // Returned byte.
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  // Strobe order, data qualification and the locked clock sequence.
  property p_one; $onehot0({ptr_load, write, read, stop}); endproperty
  property p_ptr; ptr_load |=> write || read; endproperty
  property p_wstop; write |=> stop; endproperty
  property p_rstop; read |=> !stop ##1 stop; endproperty
  property p_rdata; !$past(read) |-> rdata == 8'h00; endproperty
  property p_data; !(ptr_load || write) |-> data == 8'h00; endproperty
  property p_ext; write && data == 8'h50 && $past(data) == 8'h00 |-> $past(write, 3) && $past(data, 3) == 8'h10;
  endproperty
  property p_sr; soft_reset |=> !soft_reset; endproperty
  a_one: assert property (p_one) else $error("strobes overlap");
  a_ptr: assert property (p_ptr) else $error("no access after pointer");
  a_wstop: assert property (p_wstop) else $error("no stop after write");
  a_rstop: assert property (p_rstop) else $error("bad stop after read");
  a_rdata: assert property (p_rdata) else $error("stray read data");
  a_data: assert property (p_data) else $error("stray data");
  a_ext: assert property (p_ext) else $error("clock select out of order");
  a_sr: assert property (p_sr) else $error("long reset pulse");
  c_rd: cover property (read);
  c_sr: cover property (soft_reset);
  c_ext: cover property (write && data == 8'h50);
endmodule

// *** verification/pwm_mode_sleep_restart_control_tb_top.sv ***
// Testbench joining both ends of the mode link.
`timescale 1ns/1ps
module pwm_mode_sleep_restart_control_tb_top;
  logic clock = 0, arst_n = 0, sw_wr = 0, sw_rd = 0, ext_pin = 0;
  logic [1:0] sw_addr = 0;
  logic [7:0] sw_wdata = 0, sw_rdata, v, r, ch;
  logic [15:0] chan, e;
  logic ext_sel, s1, s2, s3, bc, act;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  mode_link_if link ();
  // Both ends and the link checker.
  pwm_mode_controller #(.STARTUP_CYCLES(20)) i_pwm_mode_controller (.clock(clock), .arst_n(arst_n),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(link));
  pwm_mode_device #(.STARTUP_CYCLES(20), .OSC_DIV(2)) i_pwm_mode_device (.clock(clock), .arst_n(arst_n),
    .link(link), .ext_clock_pin(ext_pin), .channel_output(chan), .external_clock_select(ext_sel),
    .secondary_address_one_enable(s1), .secondary_address_two_enable(s2),
    .secondary_address_three_enable(s3), .broadcast_address_enable(bc), .pwm_active(act));
  mode_link_asserts i_mode_link_asserts (.clock(clock), .arst_n(arst_n), .ptr_load(link.ptr_load),
    .write(link.write), .read(link.read), .stop(link.stop), .soft_reset(link.soft_reset),
    .data(link.data), .rdata(link.rdata));
  always #2.5 clock = ~clock;
  // Cycle count, a 50 MHz pin clock and the hang limit.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    ext_pin <= cyc[1];
    if (cyc == 90000)
    begin
      n_mismatch++;
      test_done;
    end
  end
  task automatic test_done;
    $display("Counts: %0d tests, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Compares one byte.
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      n_mismatch++;
  endtask
  // Software port write and read; read data stands the cycle after the strobe.
  task automatic swr(input logic [1:0] a, input logic [7:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic swd(input logic [1:0] a);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
    @(posedge clock);
  endtask
  // One device command, then poll busy under a bound.
  task automatic op(input logic [7:0] c, input logic [7:0] t, input logic [7:0] d);
    swr(mode_pkg::HREG_TARGET, t);
    swr(mode_pkg::HREG_DATA, d);
    swr(mode_pkg::HREG_CMD, c);
    v = 8'h80;
    for (int i = 0; i < 200 && v[7] !== 1'b0; i++)
      swd(mode_pkg::HREG_STATUS);
    if (v[7] !== 1'b0)
      cmp8(v, 8'h00);
  endtask
  task automatic wr(input logic [7:0] t, input logic [7:0] d);
    op(mode_pkg::CMD_WRITE, t, d);
  endtask
  task automatic get(input logic [7:0] t);
    op(mode_pkg::CMD_READ, t, 8'($urandom));
    swd(mode_pkg::HREG_DATA);
  endtask
  task automatic rd(input logic [7:0] t, input logic [7:0] e);
    get(t);
    cmp8(v, e);
  endtask
  // Expected outputs when only the channel whose off-high byte is a is lit.
  function automatic logic [15:0] lit(input logic [7:0] a);
    return 16'h0001 << ((a - 8'h09) >> 2);
  endfunction
  // Main sequence.
  initial
  begin
    void'($urandom(2756));
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rd(mode_pkg::REG_MODE, 8'h11);
    cmp8({3'h0, act, s1, s2, s3, bc}, 8'h01);
    $display("Test reset done");
    r = 8'h10 | (8'($urandom) & 8'h0f);
    wr(mode_pkg::REG_MODE, r);
    rd(mode_pkg::REG_MODE, r);
    cmp8({3'h0, act, s1, s2, s3, bc}, {4'h0, r[3:0]});
    wr(mode_pkg::REG_DIVIDER, 8'h03);
    rd(mode_pkg::REG_DIVIDER, 8'h03);
    wr(mode_pkg::REG_MODE, 8'h01);
    wr(mode_pkg::REG_DIVIDER, 8'($urandom));
    rd(mode_pkg::REG_DIVIDER, 8'h03);
    cmp8({7'h0, act}, 8'h01);
    $display("Test mode bits done");
    ch = 8'h09 + 8'($urandom_range(15) * 4);
    wr(ch, 8'h00);
    wr(mode_pkg::REG_MODE, 8'h11);
    rd(mode_pkg::REG_MODE, 8'h11);
    for (int i = 0; i < 3000 && v !== 8'h91; i++)
      get(mode_pkg::REG_MODE);
    cmp8(v, 8'h91);
    wr(mode_pkg::REG_MODE, 8'h01);
    rd(mode_pkg::REG_MODE, 8'h81);
    wr(mode_pkg::REG_MODE, 8'h81);
    rd(mode_pkg::REG_MODE, 8'h01);
    rd(ch, 8'h00);
    wr(ch - 8'h02, 8'h10);
    e = lit(ch);
    cmp8(chan[7:0], e[7:0]);
    cmp8(chan[15:8], e[15:8]);
    $display("Test restart done");
    wr(ch, 8'h10);
    cmp8(chan[7:0] | chan[15:8], 8'h00);
    wr(mode_pkg::REG_MODE, 8'h11);
    cmp8({7'h0, act}, 8'h00);
    rd(mode_pkg::REG_MODE, 8'h11);
    $display("Test shutdown done");
    op(mode_pkg::CMD_EXTERNAL_CLOCK_SELECT, 8'h00, 8'h00);
    rd(mode_pkg::REG_MODE, 8'h50);
    cmp8({7'h0, ext_sel}, 8'h01);
    wr(mode_pkg::REG_MODE, 8'h01);
    cmp8({7'h0, act}, 8'h01);
    rd(mode_pkg::REG_MODE, 8'h41);
    $display("Test external clock done");
    op(mode_pkg::CMD_RESET, 8'h00, 8'h00);
    rd(mode_pkg::REG_MODE, 8'h11);
    cmp8({7'h0, ext_sel}, 8'h00);
    $display("Test soft reset done");
    test_done;
  end
endmodule

// *** verilog/mode_link_if.sv ***
// Byte link between the bus controller and the PWM mode device.
`timescale 1ns/1ps
interface mode_link_if;
  logic ptr_load; // Load the register pointer from data.
  logic write; // Write data to the pointed register.
  logic read; // Read the pointed register.
  logic stop; // End of a bus transfer.
  logic soft_reset; // Software reset command.
  logic [7:0] data; // Controller to device byte.
  logic [7:0] rdata; // Device to controller byte.
  modport device (input ptr_load, write, read, stop, soft_reset, data, output rdata);
  modport controller (output ptr_load, write, read, stop, soft_reset, data, input rdata);
endinterface

// *** verilog/mode_pkg.sv ***
// Register map, bit positions, reset values, commands and timing of the PWM mode block.
package mode_pkg;
  // Device register numbers.
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_SECONDARY_MODE_CONTROL = 8'h01;
  localparam logic [7:0] REG_CH_FIRST = 8'h06;
  localparam logic [7:0] REG_CH_LAST = 8'h45;
  localparam logic [7:0] REG_ALL_FIRST = 8'hfa;
  localparam logic [7:0] REG_ALL_LAST = 8'hfd;
  localparam logic [7:0] REG_DIVIDER = 8'hfe;
  // Bit positions in the two mode registers and in the off-high byte.
  localparam int RESUME_BIT = 7;
  localparam int EXT_BIT = 6;
  localparam int AUTO_BIT = 5;
  localparam int SLEEP_BIT = 4;
  localparam int SUB_ONE_BIT = 3;
  localparam int SUB_TWO_BIT = 2;
  localparam int SUB_THREE_BIT = 1;
  localparam int BCAST_BIT = 0;
  localparam int OCH_BIT = 3;
  localparam int FULL_BIT = 4;
  // Reset values and writable masks.
  localparam logic [7:0] MODE_RESET = 8'h11;
  localparam logic [7:0] SECONDARY_MODE_CONTROL_RESET = 8'h04;
  localparam logic [7:0] SECONDARY_MODE_CONTROL_MASK = 8'h1f;
  localparam logic [7:0] HIGH_MASK = 8'h1f;
  localparam logic [7:0] OFF_HIGH_RESET = 8'h10;
  localparam logic [7:0] DIVIDER_RESET = 8'h1e;
  // Mode values sent by the locked external clock sequence.
  localparam logic [7:0] EXT_FIRST = 8'h10;
  localparam logic [7:0] EXT_SECOND = 8'h50;
  // Channel storage and PWM frame.
  localparam int CH_BYTES = 64;
  localparam logic [11:0] COUNT_LAST = 12'hfff;
  // Oscillator start-up time and its cycle count at the system clock rate.
  localparam int STARTUP_US = 500;
  localparam int CLOCK_MHZ = 200;
  localparam int STARTUP_CYCLES = STARTUP_US * CLOCK_MHZ;
  localparam int OSC_DIV = 8;
  // Controller software registers and commands.
  localparam logic [1:0] HREG_TARGET = 2'h0;
  localparam logic [1:0] HREG_DATA = 2'h1;
  localparam logic [1:0] HREG_CMD = 2'h2;
  localparam logic [1:0] HREG_STATUS = 2'h3;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [7:0] CMD_EXTERNAL_CLOCK_SELECT = 8'h03;
  localparam logic [7:0] CMD_RESET = 8'h04;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_hold = 3'b001,
    st_point = 3'b010,
    st_move = 3'b011,
    st_capture = 3'b100,
    st_close = 3'b101
  } host_state_e;
endpackage

// *** verilog/pwm_mode_controller.sv ***
// Controller end: software register port driving byte transfers to the PWM mode device.
`timescale 1ns/1ps
module pwm_mode_controller #(
  parameter int STARTUP_CYCLES = mode_pkg::STARTUP_CYCLES // Wake wait in clock cycles.
) (
  input wire logic clock, // System clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [1:0] sw_addr, // Software register address.
  input wire logic [7:0] sw_wdata, // Software write data.
  input wire logic sw_wr, // Software write strobe.
  input wire logic sw_rd, // Software read strobe.
  output logic [7:0] sw_rdata, // Software read data, one cycle after the strobe.
  mode_link_if.controller link // Byte link to the device.
);
  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  mode_pkg::host_state_e state;
  mode_pkg::host_state_e next_state;
  logic [7:0] target;
  logic [7:0] out_data;
  logic [7:0] in_data;
  logic op_read;
  logic ext_seq;
  logic ext_second;
  logic sleep_view;
  logic ext_view;
  logic [CW-1:0] wait_count;
  logic reset_pulse;
  logic [7:0] ptr_value;
  logic [7:0] send_byte;
  logic cmd_wr;
  logic guarded;
  logic mode_send;

  assign cmd_wr = sw_wr && sw_addr == mode_pkg::HREG_CMD && state == mode_pkg::st_idle;
  assign ptr_value = ext_seq ? mode_pkg::REG_MODE : target;
  assign send_byte = ext_seq ? (ext_second ? mode_pkg::EXT_SECOND : mode_pkg::EXT_FIRST) : out_data;
  assign mode_send = state == mode_pkg::st_move && !op_read && ptr_value == mode_pkg::REG_MODE;
  // PWM bytes and the resume write wait out the oscillator start-up.
  assign guarded = wait_count != '0 && ((target >= mode_pkg::REG_CH_FIRST && target <= mode_pkg::REG_CH_LAST)
                 || (target >= mode_pkg::REG_ALL_FIRST && target <= mode_pkg::REG_ALL_LAST)
                 || (target == mode_pkg::REG_MODE && out_data[mode_pkg::RESUME_BIT]));

  // Transfer sequencer.
  always_comb
  begin
    next_state = state;
    case (state)
      mode_pkg::st_idle:
        if (cmd_wr && sw_wdata == mode_pkg::CMD_WRITE)
          next_state = mode_pkg::st_hold;
        else if (cmd_wr && (sw_wdata == mode_pkg::CMD_READ || sw_wdata == mode_pkg::CMD_EXTERNAL_CLOCK_SELECT))
          next_state = mode_pkg::st_point;
      mode_pkg::st_hold:
        if (!guarded)
          next_state = mode_pkg::st_point;
      mode_pkg::st_point:
        next_state = mode_pkg::st_move;
      mode_pkg::st_move:
        next_state = op_read ? mode_pkg::st_capture : mode_pkg::st_close;
      mode_pkg::st_capture:
        next_state = mode_pkg::st_close;
      mode_pkg::st_close:
        next_state = (ext_seq && !ext_second) ? mode_pkg::st_point : mode_pkg::st_idle;
      default:
        next_state = mode_pkg::st_idle;
    endcase
  end

  // State, operation flags and the outgoing link byte.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= mode_pkg::st_idle;
      op_read <= 1'b0;
      ext_seq <= 1'b0;
      ext_second <= 1'b0;
      link.data <= 8'h00;
      reset_pulse <= 1'b0;
    end
    else
    begin
      state <= next_state;
      reset_pulse <= cmd_wr && sw_wdata == mode_pkg::CMD_RESET;
      if (cmd_wr)
      begin
        op_read <= sw_wdata == mode_pkg::CMD_READ;
        ext_seq <= sw_wdata == mode_pkg::CMD_EXTERNAL_CLOCK_SELECT;
        ext_second <= 1'b0;
      end
      else if (state == mode_pkg::st_close && ext_seq)
        ext_second <= 1'b1;
      if (next_state == mode_pkg::st_point)
        link.data <= ptr_value;
      else if (next_state == mode_pkg::st_move && !op_read)
        link.data <= send_byte; // A read leaves the data byte at zero.
      else
        link.data <= 8'h00;
    end
  end

  // Software registers and captured read byte.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      target <= 8'h00;
      out_data <= 8'h00;
      in_data <= 8'h00;
      sw_rdata <= 8'h00;
    end
    else
    begin
      if (sw_wr && sw_addr == mode_pkg::HREG_TARGET && state == mode_pkg::st_idle)
        target <= sw_wdata;
      if (sw_wr && sw_addr == mode_pkg::HREG_DATA && state == mode_pkg::st_idle)
        out_data <= sw_wdata;
      if (state == mode_pkg::st_capture)
        in_data <= link.rdata;
      if (!sw_rd)
        sw_rdata <= 8'h00;
      else
        case (sw_addr)
          mode_pkg::HREG_TARGET: sw_rdata <= target;
          mode_pkg::HREG_DATA: sw_rdata <= in_data;
          mode_pkg::HREG_STATUS: sw_rdata <= {state != mode_pkg::st_idle, wait_count != '0, sleep_view, ext_view, 4'h0};
          default: sw_rdata <= 8'h00;
        endcase
    end
  end

  // Tracks the device's sleep and clock state and times the wake wait.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sleep_view <= 1'b1;
      ext_view <= 1'b0;
      wait_count <= '0;
    end
    else if (reset_pulse)
    begin
      sleep_view <= 1'b1;
      ext_view <= 1'b0;
      wait_count <= '0;
    end
    else if (mode_send)
    begin
      sleep_view <= send_byte[mode_pkg::SLEEP_BIT];
      if (send_byte[mode_pkg::EXT_BIT] && send_byte[mode_pkg::SLEEP_BIT] && sleep_view)
        ext_view <= 1'b1;
      if (sleep_view && !send_byte[mode_pkg::SLEEP_BIT] && !ext_view)
        wait_count <= CW'(STARTUP_CYCLES);
    end
    else if (wait_count != '0)
      wait_count <= wait_count - CW'(1);
  end

  // Link strobes follow the sequencer state; the soft reset strobe follows the reset command.
  assign link.ptr_load = state == mode_pkg::st_point;
  assign link.write = state == mode_pkg::st_move && !op_read;
  assign link.read = state == mode_pkg::st_move && op_read;
  assign link.stop = state == mode_pkg::st_close;
  assign link.soft_reset = reset_pulse;
endmodule

// *** verilog/pwm_mode_device.sv ***
// Device end: primary mode register with sleep, restart, clock select and the PWM timebase.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module pwm_mode_device #(
  parameter int STARTUP_CYCLES = mode_pkg::STARTUP_CYCLES, // Oscillator start-up in clock cycles.
  parameter int OSC_DIV = mode_pkg::OSC_DIV // Clock cycles per internal oscillator tick.
) (
  input wire logic clock, // System clock, 200 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  mode_link_if.device link, // Byte link from the bus controller.
  input wire logic ext_clock_pin, // External PWM clock pin.
  output logic [15:0] channel_output, // Channel PWM outputs.
  output logic external_clock_select, // Timebase taken from the pin.
  output logic secondary_address_one_enable, // Acknowledge subaddress one.
  output logic secondary_address_two_enable, // Acknowledge subaddress two.
  output logic secondary_address_three_enable, // Acknowledge subaddress three.
  output logic broadcast_address_enable, // Acknowledge the broadcast address.
  output logic pwm_active // PWM timebase running.
);
  localparam int CW = $clog2(STARTUP_CYCLES + 1);
  logic [7:0] mode;
  logic [7:0] secondary_mode_control;
  logic [7:0] divider;
  logic [7:0] pointer;
  logic [7:0] shadow [mode_pkg::CH_BYTES];
  logic [7:0] live [mode_pkg::CH_BYTES];
  logic [CW-1:0] osc_count;
  logic [7:0] osc_div_count;
  logic [2:0] ext_sync;
  logic ext_level;
  logic [7:0] scale_count;
  logic [11:0] pwm_count;
  logic halted;
  logic draining;
  logic dirty;
  logic [3:0] byte_mask;
  logic [5:0] mask_base;
  logic [7:0] ch_offset;
  logic [5:0] idx;
  logic [1:0] all_byte;
  logic ch_wr;
  logic all_wr;
  logic mode_wr;
  logic sleep_rise;
  logic output_change_timing;
  logic [7:0] wmask;
  logic [3:0] next_mask;
  logic stop_load;
  logic chan_load;
  logic any_active;
  logic osc_ready;
  logic tick;
  logic running;
  logic frame_end;
  logic [7:0] next_pointer;
  logic [15:0] next_output;

  // Access decode for the pointed register.
  assign ch_offset = pointer - mode_pkg::REG_CH_FIRST;
  assign idx = ch_offset[5:0];
  assign all_byte = pointer[1:0] + 2'h2;
  assign ch_wr = link.write && pointer >= mode_pkg::REG_CH_FIRST && pointer <= mode_pkg::REG_CH_LAST;
  assign all_wr = link.write && pointer >= mode_pkg::REG_ALL_FIRST && pointer <= mode_pkg::REG_ALL_LAST;
  assign mode_wr = link.write && pointer == mode_pkg::REG_MODE;
  assign sleep_rise = mode_wr && link.data[mode_pkg::SLEEP_BIT] && !mode[mode_pkg::SLEEP_BIT];
  assign output_change_timing = secondary_mode_control[mode_pkg::OCH_BIT];
  assign wmask = (ch_wr ? idx[0] : all_byte[0]) ? mode_pkg::HIGH_MASK : 8'hff;
  assign next_mask = ((idx[5:2] == mask_base[5:2]) ? byte_mask : 4'h0) | (4'h1 << idx[1:0]);
  assign stop_load = link.stop && dirty && !output_change_timing;
  assign chan_load = ch_wr && output_change_timing && next_mask == 4'hf;

  // Timebase: the selected clock ticks the divider and the frame counter.
  assign osc_ready = osc_count == CW'(STARTUP_CYCLES);
  assign tick = mode[mode_pkg::EXT_BIT] ? (ext_sync[1] && ext_sync[2] && !ext_level)
              : (osc_div_count == 8'(OSC_DIV - 1));
  assign running = !halted && (mode[mode_pkg::EXT_BIT] || osc_ready);
  assign frame_end = running && tick && scale_count == divider && pwm_count == mode_pkg::COUNT_LAST;

  // Pointer step after an access, with the two wrap points.
  always_comb
  begin
    if (pointer == mode_pkg::REG_CH_LAST || pointer == mode_pkg::REG_DIVIDER)
      next_pointer = mode_pkg::REG_MODE;
    else
      next_pointer = pointer + 8'h01;
  end

  // Channel activity and the next output levels.
  always_comb
  begin
    logic [11:0] on_at;
    logic [11:0] off_at;
    logic lvl;
    on_at = 12'h000;
    off_at = 12'h000;
    lvl = 1'b0;
    any_active = 1'b0;
    next_output = 16'h0000;
    for (int c = 0; c < 16; c++)
    begin
      on_at = {live[4 * c + 1][3:0], live[4 * c]};
      off_at = {live[4 * c + 3][3:0], live[4 * c + 2]};
      any_active = any_active || !live[4 * c + 3][mode_pkg::FULL_BIT];
      if (live[4 * c + 3][mode_pkg::FULL_BIT])
        lvl = 1'b0;
      else if (live[4 * c + 1][mode_pkg::FULL_BIT])
        lvl = 1'b1;
      else if (on_at <= off_at)
        lvl = pwm_count >= on_at && pwm_count < off_at;
      else
        lvl = pwm_count >= on_at || pwm_count < off_at;
      next_output[c] = lvl && !mode[mode_pkg::RESUME_BIT];
    end
  end

  // Primary mode register.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      mode <= mode_pkg::MODE_RESET;
    else if (link.soft_reset)
      mode <= mode_pkg::MODE_RESET;
    else
    begin
      if (mode_wr)
      begin
        mode[5:0] <= link.data[5:0];
        if (link.data[mode_pkg::EXT_BIT] && link.data[mode_pkg::SLEEP_BIT] && mode[mode_pkg::SLEEP_BIT])
          mode[mode_pkg::EXT_BIT] <= 1'b1;
        if (link.data[mode_pkg::RESUME_BIT])
          mode[mode_pkg::RESUME_BIT] <= 1'b0;
        if (sleep_rise && !any_active)
          mode[mode_pkg::RESUME_BIT] <= 1'b0;
      end
      if (stop_load || chan_load)
        mode[mode_pkg::RESUME_BIT] <= 1'b0;
      if (frame_end && draining)
        mode[mode_pkg::RESUME_BIT] <= 1'b1;
    end
  end

  // Sleep state: an active frame is finished before the timebase stops.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      halted <= 1'b1;
      draining <= 1'b0;
    end
    else if (link.soft_reset || (sleep_rise && !any_active) || (frame_end && draining))
    begin
      halted <= 1'b1;
      draining <= 1'b0;
    end
    else if (mode_wr && !link.data[mode_pkg::SLEEP_BIT])
    begin
      halted <= 1'b0;
      draining <= 1'b0;
    end
    else if (sleep_rise)
      draining <= 1'b1;
  end

  // Second mode register and the period divider.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      secondary_mode_control <= mode_pkg::SECONDARY_MODE_CONTROL_RESET;
      divider <= mode_pkg::DIVIDER_RESET;
    end
    else if (link.soft_reset)
    begin
      secondary_mode_control <= mode_pkg::SECONDARY_MODE_CONTROL_RESET;
      divider <= mode_pkg::DIVIDER_RESET;
    end
    else
    begin
      if (link.write && pointer == mode_pkg::REG_SECONDARY_MODE_CONTROL)
        secondary_mode_control <= link.data & mode_pkg::SECONDARY_MODE_CONTROL_MASK;
      if (link.write && pointer == mode_pkg::REG_DIVIDER && mode[mode_pkg::SLEEP_BIT])
        divider <= link.data;
    end
  end

  // Register pointer and read data.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pointer <= 8'h00;
      link.rdata <= 8'h00;
    end
    else
    begin
      if (link.ptr_load)
        pointer <= link.data;
      else if ((link.write || link.read) && mode[mode_pkg::AUTO_BIT])
        pointer <= next_pointer;
      if (!link.read)
        link.rdata <= 8'h00;
      else if (pointer == mode_pkg::REG_MODE)
        link.rdata <= mode;
      else if (pointer == mode_pkg::REG_SECONDARY_MODE_CONTROL)
        link.rdata <= secondary_mode_control;
      else if (pointer == mode_pkg::REG_DIVIDER)
        link.rdata <= divider;
      else if (pointer >= mode_pkg::REG_CH_FIRST && pointer <= mode_pkg::REG_CH_LAST)
        link.rdata <= shadow[idx];
      else
        link.rdata <= 8'h00;
    end
  end

  // Written channel bytes; kept through sleep.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      for (int i = 0; i < mode_pkg::CH_BYTES; i++)
        shadow[i] <= (i % 4 == 3) ? mode_pkg::OFF_HIGH_RESET : 8'h00;
    else if (link.soft_reset)
      for (int i = 0; i < mode_pkg::CH_BYTES; i++)
        shadow[i] <= (i % 4 == 3) ? mode_pkg::OFF_HIGH_RESET : 8'h00;
    else if (ch_wr)
      shadow[idx] <= link.data & wmask;
    else if (all_wr)
      for (int c = 0; c < 16; c++)
        shadow[4 * c + int'(all_byte)] <= link.data & wmask;
  end

  // Bytes in use by the comparators, loaded at stop, at the fourth byte or at once on an all-channel write.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      for (int i = 0; i < mode_pkg::CH_BYTES; i++)
        live[i] <= (i % 4 == 3) ? mode_pkg::OFF_HIGH_RESET : 8'h00;
    else if (link.soft_reset)
      for (int i = 0; i < mode_pkg::CH_BYTES; i++)
        live[i] <= (i % 4 == 3) ? mode_pkg::OFF_HIGH_RESET : 8'h00;
    else if (stop_load)
      live <= shadow;
    else if (chan_load)
    begin
      for (int b = 0; b < 4; b++)
        live[{idx[5:2], 2'h0} + 6'(b)] <= shadow[{idx[5:2], 2'h0} + 6'(b)];
      live[idx] <= link.data & wmask;
    end
    else if (all_wr && output_change_timing)
      for (int c = 0; c < 16; c++)
        live[4 * c + int'(all_byte)] <= link.data & wmask;
  end

  // Pending-load tracking for both output change timings.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dirty <= 1'b0;
      byte_mask <= 4'h0;
      mask_base <= 6'h00;
    end
    else if (link.soft_reset || link.stop)
    begin
      dirty <= 1'b0;
      byte_mask <= 4'h0;
    end
    else if (ch_wr || all_wr)
    begin
      dirty <= 1'b1;
      if (ch_wr)
      begin
        byte_mask <= (next_mask == 4'hf) ? 4'h0 : next_mask;
        mask_base <= idx;
      end
    end
  end

  // Oscillator start-up and tick divider; stopped while halted.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_count <= '0;
      osc_div_count <= 8'h00;
    end
    else if (halted)
    begin
      osc_count <= '0;
      osc_div_count <= 8'h00;
    end
    else
    begin
      if (!osc_ready)
        osc_count <= osc_count + CW'(1);
      osc_div_count <= (osc_div_count == 8'(OSC_DIV - 1)) ? 8'h00 : osc_div_count + 8'h01;
    end
  end

  // External pin synchroniser; a rising change counts once stages two and three agree.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_sync <= 3'h0;
      ext_level <= 1'b0;
    end
    else
    begin
      ext_sync <= {ext_sync[1:0], ext_clock_pin};
      if (ext_sync[1] == ext_sync[2])
        ext_level <= ext_sync[1];
    end
  end

  // Divider and frame counter: 4096 steps of divider plus one ticks each.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scale_count <= 8'h00;
      pwm_count <= 12'h000;
    end
    else if (link.soft_reset)
    begin
      scale_count <= 8'h00;
      pwm_count <= 12'h000;
    end
    else if (running && tick)
    begin
      if (scale_count == divider)
      begin
        scale_count <= 8'h00;
        pwm_count <= pwm_count + 12'h001;
      end
      else
        scale_count <= scale_count + 8'h01;
    end
  end

  // Channel outputs hold their level while the timebase is stopped.
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      channel_output <= 16'h0000;
    else if (link.soft_reset)
      channel_output <= 16'h0000;
    else if (running)
      channel_output <= next_output;
  end

  assign external_clock_select = mode[mode_pkg::EXT_BIT];
  assign secondary_address_one_enable = mode[mode_pkg::SUB_ONE_BIT];
  assign secondary_address_two_enable = mode[mode_pkg::SUB_TWO_BIT];
  assign secondary_address_three_enable = mode[mode_pkg::SUB_THREE_BIT];
  assign broadcast_address_enable = mode[mode_pkg::BCAST_BIT];
  assign pwm_active = running;
endmodule
